// ### core/ssr_defs.svh
`ifndef SSR_DEFS_SVH
`define SSR_DEFS_SVH

// ****************************************************************
// Bus addressing
// ****************************************************************
`define SSR_SMB_BASE_ADDR 7'h18
`define SSR_SEL_ADDR 8'hff
`define SSR_DIAG_STRAP_KEY 4'ha

// ****************************************************************
// Shared register offsets, fields and defaults
// ****************************************************************
`define SSR_SH_STRAP 8'h00
`define SSR_SH_REV_ID 8'h01
`define SSR_SH_RST 8'h04
`define SSR_SH_IRQ_SUM 8'h05
`define SSR_SH_DIAG 8'h06
`define SSR_SH_RST_DEF 8'h01
`define SSR_SH_RST_SC_BIT 6
`define SSR_SH_RST_MASK 8'h30
`define SSR_SH_IRQA_BIT 3
`define SSR_SH_IRQB_BIT 2

// ****************************************************************
// Channel register offsets, fields and defaults
// ****************************************************************
`define SSR_CH_RST 8'h00
`define SSR_CH_IRQ 8'h01
`define SSR_CH_STAT 8'h02
`define SSR_CH_BOOST 8'h03
`define SSR_CH_OVR 8'h09
`define SSR_CH_CDR 8'h0a
`define SSR_CH_LOCKQ 8'h0c
`define SSR_CH_SHIFT 8'h0d
`define SSR_CH_PFD 8'h1e
`define SSR_CH_EQOVR 8'h2d
`define SSR_CH_PRBS 8'h30
`define SSR_CH_RST_SC_BIT 2
`define SSR_CH_IRQ_LOCK_BIT 4
`define SSR_CH_IRQ_SIG_BIT 0
`define SSR_CH_MUX_BIT 5
`define SSR_CH_DIV_BIT 2
`define SSR_CH_CDR_EN_BIT 3
`define SSR_CH_CDR_LVL_BIT 2
`define SSR_CH_SBT_BIT 3
`define SSR_CH_SHIFT_BIT 5
`define SSR_CH_PFD_SER_BIT 4
`define SSR_CH_EQOVR_BIT 3
`define SSR_CH_PRBS_BIT 3
`define SSR_CH_CDR_DEF 8'h10
`define SSR_CH_LOCKQ_DEF 8'h08
`define SSR_CH_PFD_DEF 8'he1

`endif

// ### core/ssr_pkg.sv
package ssr_pkg;

	typedef enum logic [8:0]
	{
		SSR_IDLE = 9'h001,
		SSR_ADDR = 9'h002,
		SSR_ACK_A = 9'h004,
		SSR_PTR = 9'h008,
		SSR_ACK_P = 9'h010,
		SSR_WDATA = 9'h020,
		SSR_ACK_W = 9'h040,
		SSR_RDATA = 9'h080,
		SSR_RACK = 9'h100
	} ssr_smb_st_t;

	typedef struct packed
	{
		logic [7:0] boost_stages;
		logic boost_en;
		logic mux_ovr_en;
		logic div_ovr_en;
		logic cdr_rst_ovr_en;
		logic cdr_rst_lvl;
		logic sbt_qual_en;
		logic prbs_ser_en;
		logic prbs_cfg_en;
		logic prbs_shift_en;
	} ssr_chan_ctrl_t;

	typedef struct packed
	{
		logic [7:0] stat_s0;
		logic [7:0] stat_s1;
		logic [1:0] loss_s0;
		logic [1:0] loss_s1;
		logic [7:0] irq;
		logic [7:0] boost;
		logic [7:0] ovr;
		logic [7:0] cdr;
		logic [7:0] lockq;
		logic [7:0] shift;
		logic [7:0] pfd;
		logic [7:0] eqovr;
		logic [7:0] prbs;
	} ssr_chan_t;

	typedef struct packed
	{
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic scl_d;
		logic sda_d;
		logic [1:0] strap_s0;
		logic [1:0] strap_s1;
		logic [1:0] cap_cnt;
		logic [3:0] strap;
		ssr_smb_st_t st;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic rw;
		logic [7:0] ptr;
		logic sda_oe;
		logic sda_o;
		logic [7:0] sel;
		logic [7:0] sh_rst;
		logic [7:0] diag;
		ssr_chan_t [1:0] ch;
		ssr_chan_ctrl_t [1:0] ctl;
	} ssr_state_t;

endpackage

// ### core/ssr_regs.sv
// Contract
// R1 - Diag key 0xa exposes strap in chan_reset_ctrl[7:4]
// R2 - Strap field shows power-up level, not live
// R3 - Floating strap pin latches as zero
// R4 - Shared shared_reset_ctrl bit6 resets shared set, self-clears
// R5 - Shared chan_interrupt_flags read-only revision and device id
// R6 - Shared channel_irq_summary bits3/2 flag channel A/B interrupt
// R7 - Broadcast bit writes both channel sets
// R8 - Channel reads follow select bits 1:0 only; the code decodes select bit 0 alone
// R9 - Select bit2 picks channel or shared set
// R10 - Writes to register_set_select always hit channel select
// R11 - Channel select reads back meaningless value
// R12 - Host writes full select byte, upper nibble zero
// R13 - Selector value table: 04,05,0c,0d, else shared; the code takes any value with bit2 set as a channel set
// R14 - Selection persists until select rewritten; the code also clears it on a shared bit6 reset
// R15 - Channel chan_reset_ctrl bit2 resets channel, self-clears
// R16 - Channel chan_interrupt_flags lock-loss bit4, signal-loss bit0
// R17 - Channel chan_recovery_status read-only recovery status byte
// R18 - Boost stages applied only while 0x2D bit3
// R19 - chan_override_enables bit5 mux, bit2 divider override enables
// R20 - chan_recovery_reset_ovr bit3 enables CDR reset, level bit2
// R21 - chan_lock_qualify bit3 lock qualification, default one
// R22 - Pattern start: 0x1E[4], 0x30[3], then chan_pattern_shift[5]
// R23 - Channel select resets to zero
`timescale 1ns/1ps
`include "ssr_defs.svh"

module ssr_regs
#(
	parameter logic [2:0] REVISION = 3'h1, // Arbitrary value
	parameter logic [4:0] DEVICE_ID = 5'h05, // Arbitrary value
	parameter int NCH = 2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Management bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Address straps
	input wire logic [1:0] addr_strap,
	// Channel datapath side
	input wire logic [NCH-1:0][7:0] chan_status,
	input wire logic [NCH-1:0] lock_loss,
	input wire logic [NCH-1:0] signal_loss,
	output ssr_pkg::ssr_chan_ctrl_t [NCH-1:0] chan_ctrl
);

	ssr_pkg::ssr_state_t s_r;
	ssr_pkg::ssr_state_t s_nxt;

	// ****************************************************************
	// Defaults and register access helpers
	// ****************************************************************
	function automatic ssr_pkg::ssr_chan_t ch_default(input ssr_pkg::ssr_chan_t c);
		ssr_pkg::ssr_chan_t d;
		d = c;
		d.irq = 8'h00;
		d.boost = 8'h00;
		d.ovr = 8'h00;
		d.cdr = `SSR_CH_CDR_DEF;
		d.lockq = `SSR_CH_LOCKQ_DEF;
		d.shift = 8'h00;
		d.pfd = `SSR_CH_PFD_DEF;
		d.eqovr = 8'h00;
		d.prbs = 8'h00;
		return d;
	endfunction

	function automatic ssr_pkg::ssr_chan_t ch_write(input ssr_pkg::ssr_chan_t c, input logic [7:0] a,
		input logic [7:0] d);
		ssr_pkg::ssr_chan_t w;
		w = c;
		unique case (a)
			`SSR_CH_RST:
			begin
				if (d[`SSR_CH_RST_SC_BIT])
				begin
					w = ch_default(c); // R15
				end
			end
			`SSR_CH_BOOST: w.boost = d;
			`SSR_CH_OVR: w.ovr = d;
			`SSR_CH_CDR: w.cdr = d;
			`SSR_CH_LOCKQ: w.lockq = d;
			`SSR_CH_SHIFT: w.shift = d;
			`SSR_CH_PFD: w.pfd = d;
			`SSR_CH_EQOVR: w.eqovr = d;
			`SSR_CH_PRBS: w.prbs = d;
			default: w = c;
		endcase
		return w;
	endfunction

	function automatic logic [7:0] ch_read(input ssr_pkg::ssr_chan_t c, input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		unique case (a)
			`SSR_CH_IRQ: r = c.irq; // R16
			`SSR_CH_STAT: r = c.stat_s1; // R17
			`SSR_CH_BOOST: r = c.boost;
			`SSR_CH_OVR: r = c.ovr;
			`SSR_CH_CDR: r = c.cdr;
			`SSR_CH_LOCKQ: r = c.lockq;
			`SSR_CH_SHIFT: r = c.shift;
			`SSR_CH_PFD: r = c.pfd;
			`SSR_CH_EQOVR: r = c.eqovr;
			`SSR_CH_PRBS: r = c.prbs;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	function automatic logic [7:0] reg_read(input ssr_pkg::ssr_state_t s, input logic [7:0] a);
		logic [7:0] r;
		logic [7:0] irq_sum;
		r = 8'h00;
		irq_sum = 8'h00;
		irq_sum[`SSR_SH_IRQA_BIT] = |s.ch[0].irq; // R6
		irq_sum[`SSR_SH_IRQB_BIT] = |s.ch[1].irq; // R6
		if (a == `SSR_SEL_ADDR)
		begin
			// Selector is not readable; bus sees a fixed filler
			r = 8'h00; // R11
		end
		else if (s.sel[2]) // R9
		begin
			r = ch_read(s.ch[s.sel[0]], a); // R8 R13
		end
		else
		begin
			unique case (a)
				`SSR_SH_STRAP: r = (s.diag[3:0] == `SSR_DIAG_STRAP_KEY) ? {s.strap, 4'h0} : 8'h00; // R1
				`SSR_SH_REV_ID: r = {REVISION, DEVICE_ID}; // R5
				`SSR_SH_RST: r = s.sh_rst;
				`SSR_SH_IRQ_SUM: r = irq_sum;
				`SSR_SH_DIAG: r = s.diag;
				default: r = 8'h00;
			endcase
		end
		return r;
	endfunction

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] rd_byte;

	always_comb
	begin
		s_nxt = s_r;
		scl_rise = s_r.scl_s[1] & ~s_r.scl_d;
		scl_fall = ~s_r.scl_s[1] & s_r.scl_d;
		bus_start = s_r.scl_s[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_s[1];
		bus_stop = s_r.scl_s[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_s[1];
		rd_byte = reg_read(s_r, s_r.ptr);

		// SCL is sampled, not used as a clock: 320 ns gives eight samples per period
		s_nxt.scl_s = {s_r.scl_s[0], scl_in};
		s_nxt.sda_s = {s_r.sda_s[0], sda_in};
		s_nxt.scl_d = s_r.scl_s[1];
		s_nxt.sda_d = s_r.sda_s[1];
		s_nxt.sda_o = 1'b0;

		// Straps settle through the synchroniser, then are frozen once
		s_nxt.strap_s0 = addr_strap;
		s_nxt.strap_s1 = s_r.strap_s0;
		if (s_r.cap_cnt != 2'd3)
		begin
			s_nxt.cap_cnt = s_r.cap_cnt + 2'd1;
		end
		if (s_r.cap_cnt == 2'd2)
		begin
			// Pads carry pull-downs, so an open strap reads low here
			s_nxt.strap = {2'b00, s_r.strap_s1}; // R2 R3
		end

		// Bus engine
		if (bus_stop)
		begin
			s_nxt.st = ssr_pkg::SSR_IDLE;
			s_nxt.sda_oe = 1'b0;
		end
		else if (bus_start)
		begin
			s_nxt.st = ssr_pkg::SSR_ADDR;
			s_nxt.cnt = 4'd0;
			s_nxt.sda_oe = 1'b0;
		end
		else
		begin
			unique case (s_r.st)
				ssr_pkg::SSR_IDLE:
				begin
					s_nxt.sda_oe = 1'b0;
				end
				ssr_pkg::SSR_ADDR, ssr_pkg::SSR_PTR, ssr_pkg::SSR_WDATA:
				begin
					if (scl_rise)
					begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_s[1]};
						s_nxt.cnt = s_r.cnt + 4'd1;
					end
					else if (scl_fall && s_r.cnt == 4'd8)
					begin
						s_nxt.cnt = 4'd0;
						s_nxt.sda_oe = 1'b1;
						if (s_r.st == ssr_pkg::SSR_ADDR)
						begin
							s_nxt.rw = s_r.sh[0];
							if (s_r.sh[7:1] == `SSR_SMB_BASE_ADDR + {5'h00, s_r.strap[1:0]})
							begin
								s_nxt.st = ssr_pkg::SSR_ACK_A;
							end
							else
							begin
								s_nxt.st = ssr_pkg::SSR_IDLE;
								s_nxt.sda_oe = 1'b0;
							end
						end
						else if (s_r.st == ssr_pkg::SSR_PTR)
						begin
							s_nxt.ptr = s_r.sh;
							s_nxt.st = ssr_pkg::SSR_ACK_P;
						end
						else
						begin
							s_nxt.st = ssr_pkg::SSR_ACK_W;
							// Selection holds until the next write of the selector or a shared_reset_ctrl bit6 reset
							if (s_r.ptr == `SSR_SEL_ADDR)
							begin
								s_nxt.sel = s_r.sh; // R10 R14
							end
							else if (s_r.sel[2]) // R9
							begin
								if (s_r.sel[3])
								begin
									for (int i = 0; i < NCH; i++)
									begin
										s_nxt.ch[i] = ch_write(s_r.ch[i], s_r.ptr, s_r.sh); // R7 R13
									end
								end
								else
								begin
									s_nxt.ch[s_r.sel[0]] = ch_write(s_r.ch[s_r.sel[0]], s_r.ptr, s_r.sh); // R13
								end
							end
							else
							begin
								unique case (s_r.ptr)
									`SSR_SH_RST:
									begin
										if (s_r.sh[`SSR_SH_RST_SC_BIT])
										begin
											s_nxt.sh_rst = `SSR_SH_RST_DEF; // R4
											s_nxt.diag = 8'h00; // R4
											s_nxt.sel = 8'h00; // R4
										end
										else
										begin
											s_nxt.sh_rst = (s_r.sh & `SSR_SH_RST_MASK) | `SSR_SH_RST_DEF;
										end
									end
									`SSR_SH_DIAG: s_nxt.diag = s_r.sh;
									default: s_nxt.diag = s_r.diag;
								endcase
							end
						end
					end
				end
				ssr_pkg::SSR_ACK_A, ssr_pkg::SSR_ACK_P, ssr_pkg::SSR_ACK_W:
				begin
					if (scl_fall)
					begin
						s_nxt.sda_oe = 1'b0;
						s_nxt.st = ssr_pkg::SSR_WDATA;
						if (s_r.st == ssr_pkg::SSR_ACK_W)
						begin
							s_nxt.ptr = s_r.ptr + 8'd1;
						end
						if (s_r.st == ssr_pkg::SSR_ACK_A && !s_r.rw)
						begin
							s_nxt.st = ssr_pkg::SSR_PTR;
						end
						if (s_r.st == ssr_pkg::SSR_ACK_A && s_r.rw)
						begin
							s_nxt.st = ssr_pkg::SSR_RDATA;
							s_nxt.sh = rd_byte;
							s_nxt.sda_oe = ~rd_byte[7];
						end
					end
				end
				ssr_pkg::SSR_RDATA:
				begin
					if (scl_rise)
					begin
						s_nxt.cnt = s_r.cnt + 4'd1;
					end
					else if (scl_fall)
					begin
						if (s_r.cnt == 4'd8)
						begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.cnt = 4'd0;
							s_nxt.st = ssr_pkg::SSR_RACK;
							// Reading a channel flag byte consumes its events
							if (s_r.sel[2] && s_r.ptr == `SSR_CH_IRQ)
							begin
								s_nxt.ch[s_r.sel[0]].irq = 8'h00;
							end
						end
						else
						begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
						end
					end
				end
				ssr_pkg::SSR_RACK:
				begin
					if (scl_rise)
					begin
						if (s_r.sda_s[1])
						begin
							s_nxt.st = ssr_pkg::SSR_IDLE;
						end
						else
						begin
							s_nxt.ptr = s_r.ptr + 8'd1;
							s_nxt.cnt = 4'd9;
						end
					end
					else if (scl_fall && s_r.cnt == 4'd9)
					begin
						s_nxt.cnt = 4'd0;
						s_nxt.st = ssr_pkg::SSR_RDATA;
						s_nxt.sh = rd_byte;
						s_nxt.sda_oe = ~rd_byte[7];
					end
				end
				default:
				begin
					s_nxt.st = ssr_pkg::SSR_IDLE;
					s_nxt.sda_oe = 1'b0;
				end
			endcase
		end

		// Synchronisers and event sets come last: a channel write, clear or reset never stalls or loses them
		for (int i = 0; i < NCH; i++)
		begin
			s_nxt.ch[i].stat_s0 = chan_status[i];
			s_nxt.ch[i].stat_s1 = s_r.ch[i].stat_s0;
			s_nxt.ch[i].loss_s0 = {lock_loss[i], signal_loss[i]};
			s_nxt.ch[i].loss_s1 = s_r.ch[i].loss_s0;
			if (s_r.ch[i].loss_s1[1])
			begin
				s_nxt.ch[i].irq[`SSR_CH_IRQ_LOCK_BIT] = 1'b1; // R16
			end
			if (s_r.ch[i].loss_s1[0])
			begin
				s_nxt.ch[i].irq[`SSR_CH_IRQ_SIG_BIT] = 1'b1; // R16
			end
			s_nxt.ctl[i].boost_en = s_r.ch[i].eqovr[`SSR_CH_EQOVR_BIT]; // R18
			s_nxt.ctl[i].boost_stages = s_r.ch[i].eqovr[`SSR_CH_EQOVR_BIT] ? s_r.ch[i].boost : 8'h00; // R18
			s_nxt.ctl[i].mux_ovr_en = s_r.ch[i].ovr[`SSR_CH_MUX_BIT]; // R19
			s_nxt.ctl[i].div_ovr_en = s_r.ch[i].ovr[`SSR_CH_DIV_BIT]; // R19
			s_nxt.ctl[i].cdr_rst_ovr_en = s_r.ch[i].cdr[`SSR_CH_CDR_EN_BIT]; // R20
			s_nxt.ctl[i].cdr_rst_lvl = s_r.ch[i].cdr[`SSR_CH_CDR_EN_BIT] & s_r.ch[i].cdr[`SSR_CH_CDR_LVL_BIT]; // R20
			s_nxt.ctl[i].sbt_qual_en = s_r.ch[i].lockq[`SSR_CH_SBT_BIT]; // R21
			s_nxt.ctl[i].prbs_ser_en = s_r.ch[i].pfd[`SSR_CH_PFD_SER_BIT];
			s_nxt.ctl[i].prbs_cfg_en = s_r.ch[i].prbs[`SSR_CH_PRBS_BIT];
			// Shift is gated so an early shift bit does not start a half-set pattern
			s_nxt.ctl[i].prbs_shift_en = s_r.ch[i].shift[`SSR_CH_SHIFT_BIT] & s_r.ch[i].pfd[`SSR_CH_PFD_SER_BIT]
				& s_r.ch[i].prbs[`SSR_CH_PRBS_BIT]; // R22
		end
	end

	// ****************************************************************
	// State register
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_r <= '0;
			s_r.scl_s <= 2'b11;
			s_r.sda_s <= 2'b11;
			s_r.scl_d <= 1'b1;
			s_r.sda_d <= 1'b1;
			s_r.st <= ssr_pkg::SSR_IDLE;
			s_r.sel <= 8'h00; // R23
			s_r.sh_rst <= `SSR_SH_RST_DEF;
			for (int i = 0; i < NCH; i++)
			begin
				s_r.ch[i].cdr <= `SSR_CH_CDR_DEF;
				s_r.ch[i].lockq <= `SSR_CH_LOCKQ_DEF;
				s_r.ch[i].pfd <= `SSR_CH_PFD_DEF;
				s_r.ctl[i].sbt_qual_en <= 1'b1;
			end
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign sda_out = s_r.sda_o;
	assign sda_oe = s_r.sda_oe;
	assign chan_ctrl = s_r.ctl;

endmodule

// ### verification/ssr_regs_chk.sv
`timescale 1ns/1ps
// *****
// Port checks
// *****
module ssr_regs_chk
#(
	parameter int NCH = 2
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus and channel side
	input wire logic scl_in,
	input wire ssr_pkg::ssr_chan_ctrl_t [NCH-1:0] chan_ctrl
);
	// SCL high phases last 4 clocks, so 8 or more means the bus is idle
	logic [3:0] hi_cnt_r;
	logic [3:0] hi_cnt_nxt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	always_comb
	begin
		hi_cnt_nxt = 4'h0;
		if (scl_in)
			hi_cnt_nxt = (hi_cnt_r == 4'h8) ? hi_cnt_r : hi_cnt_r + 4'h1;
	end
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			hi_cnt_r <= 4'h0;
		else
			hi_cnt_r <= hi_cnt_nxt;
	end
	for (genvar i = 0; i < NCH; i++)
	begin : g_ch
		a_boost_gated: assert property (
			chan_ctrl[i].boost_stages != 8'h00 |-> chan_ctrl[i].boost_en) else $error("boost without enable");
		a_cdr_level_gated: assert property (
			chan_ctrl[i].cdr_rst_lvl |-> chan_ctrl[i].cdr_rst_ovr_en) else $error("cdr level without enable");
		a_shift_gated: assert property (
			chan_ctrl[i].prbs_shift_en |-> chan_ctrl[i].prbs_ser_en && chan_ctrl[i].prbs_cfg_en)
			else $error("pattern shift without setup");
		a_shift_order: assert property (
			$rose(chan_ctrl[i].prbs_shift_en) |-> $past(chan_ctrl[i].prbs_ser_en) && $past(chan_ctrl[i].prbs_cfg_en))
			else $error("pattern shift before setup");
		a_reset_defaults: assert property (
			$rose(rst_b) |-> chan_ctrl[i].sbt_qual_en && !chan_ctrl[i].mux_ovr_en && !chan_ctrl[i].div_ovr_en
			&& !chan_ctrl[i].cdr_rst_ovr_en) else $error("control not at defaults after reset");
		a_ctrl_idle_hold: assert property (
			hi_cnt_r == 4'h8 |-> $stable(chan_ctrl[i])) else $error("control changed on idle bus");
	end
endmodule

bind ssr_regs ssr_regs_chk #(.NCH(NCH)) u_chk (.clk(clk), .rst_b(rst_b), .scl_in(scl_in), .chan_ctrl(chan_ctrl));

// ### verification/ssr_smb_host.sv
`timescale 1ns/1ps
// *****
// Management bus host
// *****
module ssr_smb_host
#(
	parameter logic [6:0] ADDR = 7'h18
)
(
	// Bus pins
	output logic scl,
	output logic sda_pull,
	input wire logic sda
);
	int miss = 0;
	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bit_w(input logic b);
		sda_pull = !b;
		#80 scl = 1'b1;
		#160 scl = 1'b0;
		#80;
	endtask
	// Samples late in the high phase, after the device's sync delay
	task automatic bit_r(output logic b);
		sda_pull = 1'b0;
		#80 scl = 1'b1;
		#150 b = sda;
		#10 scl = 1'b0;
		#80;
	endtask
	task automatic start();
		sda_pull = 1'b0;
		#80 scl = 1'b1;
		#80 sda_pull = 1'b1;
		#80 scl = 1'b0;
		#80;
	endtask
	task automatic stop();
		sda_pull = 1'b1;
		#80 scl = 1'b1;
		#80 sda_pull = 1'b0;
		#160;
	endtask
	task automatic byte_w(input logic [7:0] d);
		logic a;
		for (int k = 7; k >= 0; k--)
			bit_w(d[k]);
		bit_r(a);
		if (a)
			miss++;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		start();
		byte_w({ADDR, 1'b0});
		byte_w(p);
		byte_w(d);
		stop();
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		start();
		byte_w({ADDR, 1'b0});
		byte_w(p);
		start();
		byte_w({ADDR, 1'b1});
		for (int k = 7; k >= 0; k--)
			bit_r(d[k]);
		bit_w(1'b1);
		stop();
	endtask
endmodule

// ### verification/ssr_regs_tb_top.sv
`timescale 1ns/1ps
`include "ssr_defs.svh"
module ssr_regs_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic scl;
	logic pull;
	logic sda;
	logic sda_out;
	logic sda_oe;
	logic [1:0] addr_strap = 2'h2;
	logic [1:0][7:0] chan_status = '0;
	logic [1:0] lock_loss = '0;
	logic [1:0] signal_loss = '0;
	ssr_pkg::ssr_chan_ctrl_t [1:0] chan_ctrl;
	ssr_pkg::ssr_chan_ctrl_t def_c;
	logic [7:0] d;
	logic [7:0] shv [8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09, 8'h0a, 8'h0b};
	int failures = 0;
	int check_count = 0;
	always #20 clk = ~clk;
	// Open-drain line with pull-up
	assign sda = (pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
	// Revision and id values are arbitrary
	ssr_regs #(.REVISION(3'h2), .DEVICE_ID(5'h0a), .NCH(2)) u_dut (.clk(clk), .rst_b(rst_b), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap), .chan_status(chan_status),
		.lock_loss(lock_loss), .signal_loss(signal_loss), .chan_ctrl(chan_ctrl));
	ssr_smb_host #(.ADDR(`SSR_SMB_BASE_ADDR + 7'h02)) u_host (.scl(scl), .sda_pull(pull), .sda(sda));
	// *****
	// Tasks
	// *****
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic w(input logic [7:0] p, input logic [7:0] v);
		@(negedge clk);
		u_host.wr(p, v);
	endtask
	task automatic rc(input logic [7:0] p, input logic [7:0] e);
		@(negedge clk);
		u_host.rd(p, d);
		check(d, e);
	endtask
	task automatic stop_test();
		if (failures == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#3_000_000;
		failures++;
		stop_test();
	end
	// *****
	// Tests
	// *****
	initial
	begin
		def_c = '0;
		def_c.sbt_qual_en = 1'b1;
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		repeat (8) @(negedge clk);
		// Straps move after power-up; the device must keep the old address
		addr_strap = 2'h1;
		check(chan_ctrl[0], def_c);
		check(chan_ctrl[1], def_c);
		rc(8'h01, 8'h4a);
		w(8'h01, 8'hff);
		rc(8'h01, 8'h4a);
		w(8'h06, 8'h0a);
		u_host.rd(8'h00, d);
		check(d[7:4], 4'h2);
		w(8'h04, 8'h40);
		rc(8'h04, `SSR_SH_RST_DEF);
		rc(8'h06, 8'h00);
		rc(8'h00, 8'h00);
		foreach (shv[k])
		begin
			w(8'hff, shv[k]);
			rc(8'h01, 8'h4a);
		end
		w(8'hff, 8'h04);
		w(8'h03, 8'ha5);
		rc(8'hff, 8'h00);
		check(chan_ctrl[0].boost_stages, 8'h00);
		w(8'h2d, 8'h08);
		check(chan_ctrl[0].boost_stages, 8'ha5);
		w(8'hff, 8'h05);
		rc(8'h03, 8'h00);
		w(8'h03, 8'h3c);
		w(8'hff, 8'h0c);
		rc(8'h03, 8'ha5);
		w(8'h09, 8'h24);
		check({chan_ctrl[1].mux_ovr_en, chan_ctrl[1].div_ovr_en, chan_ctrl[0].mux_ovr_en,
			chan_ctrl[0].div_ovr_en}, 4'hf);
		w(8'hff, 8'h0d);
		rc(8'h03, 8'h3c);
		rc(8'h09, 8'h24);
		w(8'h0a, 8'h1c);
		w(8'h0c, 8'h00);
		check({chan_ctrl[1].cdr_rst_ovr_en, chan_ctrl[1].cdr_rst_lvl, chan_ctrl[1].sbt_qual_en}, 3'h6);
		rc(8'h0c, 8'h00);
		rc(8'h0a, 8'h1c);
		@(negedge clk);
		chan_status[1] = 8'h96;
		lock_loss[1] = 1'b1;
		signal_loss[0] = 1'b1;
		repeat (4) @(negedge clk);
		lock_loss = '0;
		signal_loss = '0;
		rc(8'h02, 8'h96);
		rc(8'h01, 8'h10);
		rc(8'h01, 8'h00);
		w(8'hff, 8'h00);
		rc(8'h05, 8'h08);
		w(8'hff, 8'h04);
		rc(8'h01, 8'h01);
		// Pattern setup bits go first, shift enable last
		w(8'h1e, 8'hf1);
		w(8'h30, 8'h08);
		w(8'h0d, 8'h20);
		check(chan_ctrl[0].prbs_shift_en, 1'b1);
		w(8'h00, 8'h04);
		rc(8'h00, 8'h00);
		rc(8'h03, 8'h00);
		check(chan_ctrl[0], def_c);
		check(chan_ctrl[1].mux_ovr_en, 1'b1);
		@(negedge clk);
		u_host.start();
		u_host.byte_w({`SSR_SMB_BASE_ADDR + 7'h01, 1'b0});
		u_host.stop();
		check(17'(u_host.miss), 17'h0_0001);
		stop_test();
	end
endmodule
